// >>> dcl_chan_bank.sv
`timescale 1ns/1ps
module dcl_chan_bank
   import dcl_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   dcl_chan_if.bank  ch
);
   // ----------------------------------------------------------------
   // Per-channel latch and output stage
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_CH; g++)
   begin : g_ch
      logic [PIX_W-1:0] held_q, held_d;
      logic [PIX_W-1:0] shown_q, shown_d;

      always_comb
      begin
         held_d  = held_q;
         shown_d = shown_q;
         if (ch.load && (ch.idx == CH_IDX_W'(g)))
         begin
            held_d = ch.word;
         end
         if (ch.copy)
         begin
            // Copy sees the old latch, so a same-cycle load waits for the next copy
            shown_d = held_q;
         end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            held_q  <= '0;
            shown_q <= '0;
         end
         else
         begin
            held_q  <= held_d;
            shown_q <= shown_d;
         end
      end

      assign ch.shown[g] = shown_q;
   end
endmodule

// >>> dcl_chan_if.sv
`timescale 1ns/1ps
interface dcl_chan_if;
   import dcl_pkg::*;

   logic                             load;
   logic [CH_IDX_W-1:0]              idx;
   logic [PIX_W-1:0]                 word;
   logic                             copy;
   logic [NUM_CH-1:0][PIX_W-1:0]     shown;

   modport bank (input load, input idx, input word, input copy, output shown);
   modport core (output load, output idx, output word, output copy, input shown);
endinterface

// >>> dcl_fifo.sv
`timescale 1ns/1ps
module dcl_fifo
#(
   parameter int unsigned WIDTH = 13,
   parameter int unsigned DEPTH = 16
)
(
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       in_valid,
   output      logic                       in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   output      logic                       out_valid,
   input  wire logic                       out_ready,
   output      logic [WIDTH-1:0]           out_data,
   output      logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int unsigned PTR_W = $clog2(DEPTH);
   localparam int unsigned CNT_W = $clog2(DEPTH+1);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic             push, pop;

   assign in_ready  = (cnt_q != CNT_FULL);
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign level     = cnt_q;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb
   begin
      mem_d = mem_q;
      wr_d  = wr_q;
      rd_d  = rd_q;
      cnt_d = cnt_q;
      if (push)
      begin
         mem_d[wr_q] = in_data;
         wr_d        = (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
         rd_d = (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop)
      begin
         cnt_d = cnt_q + 1'b1;
      end
      else if (pop && !push)
      begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_q[i] <= '0;
         end
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         mem_q <= mem_d;
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end
endmodule

// >>> dcl_loader.sv
`timescale 1ns/1ps
module dcl_loader
   import dcl_pkg::*;
(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [ADDR_W-1:0]       paddr,
   input  wire logic [31:0]             pwdata,
   output      logic [31:0]             prdata,
   output      logic                    pready,
   output      logic                    pslverr,
   input  wire logic                    pixel_clk,
   input  wire logic [PIX_W-1:0]        pixel_word_in,
   input  wire logic                    sequence_start_strobe,
   input  wire logic                    output_transfer_strobe,
   output      logic [NUM_CH*PIX_W-1:0] channel_outputs,
   output      logic                    white_level_sel
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   dcl_chan_if ch ();

   logic                        pix_prev_q, pix_prev_d;
   logic                        pix_rise, pix_fall, active_edge;

   dcl_cap_state_t              state_q, state_d;
   logic                        start_seen_q, start_seen_d;
   logic [CH_IDX_W-1:0]         cap_idx_q, cap_idx_d;
   logic [CH_IDX_W-1:0]         cap_cnt_q, cap_cnt_d;
   logic                        cap_right_q, cap_right_d;
   logic                        push;
   logic [ENTRY_W-1:0]          push_entry;
   logic                        ovf_set, ign_set;

   logic                        fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [ENTRY_W-1:0]          fifo_out_data;
   logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level;

   logic                        xfr_det_q, xfr_det_d;
   logic                        inv_stage_q, inv_stage_d;
   logic                        white_q, white_d;
   logic                        copy;

   logic [31:0]                 ctrl_q, ctrl_d;
   logic                        ovf_q, ovf_d, ign_q, ign_d;
   logic [31:0]                 prdata_q, prdata_d;
   logic                        pready_q, pready_d;
   logic                        pslverr_q, pslverr_d;
   logic                        setup, wr_access;
   logic                        chan_hit;
   logic [ADDR_W-1:0]           chan_off;
   logic [CH_IDX_W-1:0]         chan_idx;
   logic [31:0]                 status;

   // ----------------------------------------------------------------
   // Pixel clock edges
   // ----------------------------------------------------------------
   // Pixel clock is slow against pclk and synchronous, so it is sampled directly
   assign pix_prev_d  = pixel_clk;
   assign pix_rise    = pixel_clk & ~pix_prev_q;
   assign pix_fall    = ~pixel_clk & pix_prev_q;
   assign active_edge = ctrl_q[CTRL_EVEN_BIT] ? pix_rise : pix_fall;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pix_prev_q <= 1'b0;
      end
      else
      begin
         pix_prev_q <= pix_prev_d;
      end
   end

   // ----------------------------------------------------------------
   // Word capture
   // ----------------------------------------------------------------
   // Channel index travels with the word, so a lost word cannot shift the rest
   assign push_entry = {cap_idx_d, pixel_word_in};

   always_comb
   begin
      state_d      = state_q;
      start_seen_d = start_seen_q;
      cap_idx_d    = cap_idx_q;
      cap_cnt_d    = cap_cnt_q;
      cap_right_d  = cap_right_q;
      push         = 1'b0;
      ign_set      = 1'b0;
      if (active_edge)
      begin
         start_seen_d = sequence_start_strobe;
         if (start_seen_q)
         begin
            cap_right_d = ctrl_q[CTRL_RIGHT_BIT];
            cap_idx_d   = ctrl_q[CTRL_RIGHT_BIT] ? CH_FIRST_RIGHT : CH_FIRST_LEFT;
            cap_cnt_d   = CH_STEP;
            push        = 1'b1;
            state_d     = CAP_OPEN;
         end
         else
         begin
            case (state_q)
               CAP_IDLE:
               begin
                  state_d = CAP_IDLE;
               end
               CAP_OPEN:
               begin
                  cap_idx_d = cap_right_q ? cap_idx_q - CH_STEP : cap_idx_q + CH_STEP;
                  cap_cnt_d = cap_cnt_q + CH_STEP;
                  push      = 1'b1;
               end
               CAP_FULL:
               begin
                  ign_set = 1'b1;
               end
               default:
               begin
                  state_d = CAP_IDLE;
               end
            endcase
         end
         if (push && (cap_cnt_d == CH_COUNT))
         begin
            state_d = CAP_FULL;
         end
      end
   end

   assign ovf_set = push & ~fifo_in_ready;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q      <= CAP_IDLE;
         start_seen_q <= 1'b0;
         cap_idx_q    <= CH_FIRST_LEFT;
         cap_cnt_q    <= '0;
         cap_right_q  <= 1'b0;
      end
      else
      begin
         state_q      <= state_d;
         start_seen_q <= start_seen_d;
         cap_idx_q    <= cap_idx_d;
         cap_cnt_q    <= cap_cnt_d;
         cap_right_q  <= cap_right_d;
      end
   end

   // ----------------------------------------------------------------
   // Word buffer and channel latches
   // ----------------------------------------------------------------
   // Hold bit stalls the drain, letting software freeze the latches
   assign fifo_out_ready = ~ctrl_q[CTRL_HOLD_BIT];

   dcl_fifo #(
      .WIDTH (ENTRY_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (pclk),
      .rst_n     (presetn),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (push_entry),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data),
      .level     (fifo_level)
   );

   assign ch.load = fifo_out_valid & fifo_out_ready;
   assign ch.idx  = fifo_out_data[ENTRY_W-1:PIX_W];
   assign ch.word = fifo_out_data[PIX_W-1:0];
   assign ch.copy = copy;

   dcl_chan_bank u_bank (
      .pclk    (pclk),
      .presetn (presetn),
      .ch      (ch.bank)
   );

   // ----------------------------------------------------------------
   // Transfer and polarity
   // ----------------------------------------------------------------
   always_comb
   begin
      xfr_det_d   = xfr_det_q;
      inv_stage_d = inv_stage_q;
      white_d     = white_q;
      copy        = 1'b0;
      if (pix_rise)
      begin
         xfr_det_d = output_transfer_strobe;
         if (xfr_det_q)
         begin
            copy        = 1'b1;
            inv_stage_d = ctrl_q[CTRL_INV_BIT];
            white_d     = inv_stage_q;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         xfr_det_q   <= 1'b0;
         inv_stage_q <= 1'b0;
         white_q     <= 1'b0;
      end
      else
      begin
         xfr_det_q   <= xfr_det_d;
         inv_stage_q <= inv_stage_d;
         white_q     <= white_d;
      end
   end

   assign channel_outputs = ch.shown;
   assign white_level_sel = white_q;

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   assign setup     = psel & ~penable;
   assign wr_access = psel & penable & pready_q & pwrite;
   assign chan_off  = paddr - ADDR_CHAN_BASE;
   assign chan_idx  = chan_off[CH_IDX_W+1:2];
   assign chan_hit  = (paddr >= ADDR_CHAN_BASE) && (paddr <= ADDR_CHAN_LAST)
                      && (paddr[1:0] == 2'h0);

   always_comb
   begin
      status               = '0;
      status[ST_OPEN_BIT]  = (state_q == CAP_OPEN);
      status[ST_EMPTY_BIT] = ~fifo_out_valid;
      status[ST_FULL_BIT]  = ~fifo_in_ready;
      status[ST_WHITE_BIT] = white_q;
      status[ST_XFR_BIT]   = xfr_det_q;
      status[ST_OVF_BIT]   = ovf_q;
      status[ST_IGN_BIT]   = ign_q;
   end

   always_comb
   begin
      ctrl_d    = ctrl_q;
      prdata_d  = '0;
      pready_d  = setup;
      pslverr_d = 1'b0;
      // Sticky flags: a new event beats a write-one clear in the same cycle
      ovf_d = ovf_set | (ovf_q & ~(wr_access && (paddr == ADDR_STATUS) && pwdata[ST_OVF_BIT]));
      ign_d = ign_set | (ign_q & ~(wr_access && (paddr == ADDR_STATUS) && pwdata[ST_IGN_BIT]));
      if (wr_access && (paddr == ADDR_CTRL))
      begin
         ctrl_d = pwdata & CTRL_MASK;
      end
      if (setup)
      begin
         if (paddr == ADDR_CTRL)
         begin
            prdata_d = ctrl_q;
         end
         else if (paddr == ADDR_STATUS)
         begin
            prdata_d = status;
         end
         else if (paddr == ADDR_LEVEL)
         begin
            prdata_d = 32'(fifo_level);
         end
         else if (chan_hit)
         begin
            prdata_d = 32'(ch.shown[chan_idx]);
         end
         else
         begin
            pslverr_d = 1'b1;
         end
         if (pwrite)
         begin
            prdata_d = '0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q    <= CTRL_RESET;
         ovf_q     <= 1'b0;
         ign_q     <= 1'b0;
         prdata_q  <= '0;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         ctrl_q    <= ctrl_d;
         ovf_q     <= ovf_d;
         ign_q     <= ign_d;
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
endmodule

// >>> dcl_loader_checker.sv
`timescale 1ns/1ps
module dcl_loader_checker
   import dcl_pkg::*;
(
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [ADDR_W-1:0]       paddr,
   input wire logic [31:0]             pwdata,
   input wire logic [31:0]             prdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   input wire logic                    pixel_clk,
   input wire logic [PIX_W-1:0]        pixel_word_in,
   input wire logic                    sequence_start_strobe,
   input wire logic                    output_transfer_strobe,
   input wire logic [NUM_CH*PIX_W-1:0] channel_outputs,
   input wire logic                    white_level_sel
);
   // ------------
   // Helper logic
   // ------------
   logic [5:0] since_q;
   logic [5:0] since_d;
   logic       mapped;

   // Cycles since the strobe was seen with the pixel clock high; saturates
   always_comb
   begin
      since_d = (since_q == 6'h3F) ? since_q : since_q + 6'h01;
      if (pixel_clk && output_transfer_strobe)
         since_d = 6'h00;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         since_q <= 6'h3F;
      else
         since_q <= since_d;
   end

   assign mapped = (paddr[1:0] == 2'h0) && ((paddr <= ADDR_LEVEL) ||
                   (paddr >= ADDR_CHAN_BASE && paddr <= ADDR_CHAN_LAST));

   // ------------
   // Assertions
   // ------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_ready_access: assert property (pready |-> psel && penable && $past(psel && !penable))
      else $error("pready outside an access phase");
   chk_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not a single cycle after setup");
   chk_err_unmapped: assert property (pready && !mapped |-> pslverr)
      else $error("unmapped access without pslverr");
   chk_ok_mapped: assert property (pready && mapped |-> !pslverr)
      else $error("mapped access flagged as error");
   chk_rdata_quiet: assert property (!pready || pslverr |-> prdata == 32'h0)
      else $error("prdata not zero outside a good access");
   chk_write_quiet: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("prdata not zero on a write access");
   chk_out_on_rise: assert property (!$stable(channel_outputs) |-> $past(pixel_clk))
      else $error("outputs changed away from a pixel rise");
   chk_copy_needs_req: assert property (!$stable(channel_outputs) |-> since_q < 6'h14)
      else $error("outputs changed without a transfer request");
   chk_white_with_copy: assert property ($changed(white_level_sel) |->
      $past(pixel_clk) && since_q < 6'h14)
      else $error("white level changed outside a transfer copy");
endmodule

bind dcl_loader dcl_loader_checker u_chk
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pixel_clk(pixel_clk), .pixel_word_in(pixel_word_in),
   .sequence_start_strobe(sequence_start_strobe),
   .output_transfer_strobe(output_transfer_strobe),
   .channel_outputs(channel_outputs), .white_level_sel(white_level_sel)
);

// >>> dcl_pkg.sv
// Summary of operation
// - Each pixel word is ten bits wide, with bit 9 taken as the most significant bit.
// - Sequence start is sampled on every active edge, and a sequence begins on the next active edge.
// - The active edge is the rising pixel clock edge when even/odd is high, else the falling edge.
// - With direction low a sequence starts at channel 0 going right, with it high at channel 5 going left.
// - Successive words go to successive channels on rising edges in even mode, falling in odd mode.
// - Transfer strobe is sampled on rising pixel clock edges and a request is noted whenever it is high.
// - On the rising edge after a noted request, all six latched words are copied to the outputs together.
// - The white level follows the first reference while polarity is low, the second while it is high.
// - Polarity is latched at a transfer copy edge and reaches the outputs at the next transfer copy edge.
package dcl_pkg;

   // ----------------------------------------------------------------
   // Data path sizes
   // ----------------------------------------------------------------
   localparam int unsigned PIX_W      = 10;
   localparam int unsigned NUM_CH     = 6;
   localparam int unsigned CH_IDX_W   = 3;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned ENTRY_W    = PIX_W + CH_IDX_W;
   localparam int unsigned ADDR_W     = 8;

   localparam logic [CH_IDX_W-1:0] CH_FIRST_LEFT  = 3'h0;
   localparam logic [CH_IDX_W-1:0] CH_FIRST_RIGHT = 3'h5;
   localparam logic [CH_IDX_W-1:0] CH_STEP        = 3'h1;
   localparam logic [CH_IDX_W-1:0] CH_COUNT       = 3'h6;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_CTRL      = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_LEVEL     = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_CHAN_BASE = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_CHAN_LAST = 8'h24;

   localparam int unsigned CTRL_EVEN_BIT  = 0;
   localparam int unsigned CTRL_RIGHT_BIT = 1;
   localparam int unsigned CTRL_INV_BIT   = 2;
   localparam int unsigned CTRL_HOLD_BIT  = 3;
   localparam logic [31:0] CTRL_MASK      = 32'h0000_000F;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;

   localparam int unsigned ST_OPEN_BIT  = 0;
   localparam int unsigned ST_EMPTY_BIT = 1;
   localparam int unsigned ST_FULL_BIT  = 2;
   localparam int unsigned ST_WHITE_BIT = 3;
   localparam int unsigned ST_XFR_BIT   = 4;
   localparam int unsigned ST_OVF_BIT   = 8;
   localparam int unsigned ST_IGN_BIT   = 9;

   // ----------------------------------------------------------------
   // Capture state
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      CAP_IDLE = 3'b001,
      CAP_OPEN = 3'b010,
      CAP_FULL = 3'b100
   } dcl_cap_state_t;

endpackage

// >>> dcl_tcon_model.sv
`timescale 1ns/1ps
module dcl_tcon_model
   import dcl_pkg::*;
(
   input  wire logic             pclk,
   output      logic             pixel_clk,
   output      logic [PIX_W-1:0] pixel_word_in,
   output      logic             sequence_start_strobe,
   output      logic             output_transfer_strobe
);
   initial
   begin
      pixel_clk              = 1'b0;
      pixel_word_in          = 10'h000;
      sequence_start_strobe  = 1'b0;
      output_transfer_strobe = 1'b0;
   end

   // One pixel period; inputs held across both edges, clock idles low between calls
   task automatic px(input logic st, input logic xf, input logic [PIX_W-1:0] w);
      sequence_start_strobe  <= st;
      output_transfer_strobe <= xf;
      pixel_word_in          <= w;
      repeat (4) @(posedge pclk);
      pixel_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      pixel_clk <= 1'b0;
      repeat (3) @(posedge pclk);
      // Hold time over: data no longer valid, so show a different pattern
      pixel_word_in          <= ~w;
      sequence_start_strobe  <= 1'b0;
      output_transfer_strobe <= 1'b0;
      @(posedge pclk);
   endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import dcl_pkg::*;
   logic                    pclk;
   logic                    presetn;
   logic                    psel;
   logic                    penable;
   logic                    pwrite;
   logic [ADDR_W-1:0]       paddr;
   logic [31:0]             pwdata;
   logic [31:0]             prdata;
   logic                    pready;
   logic                    pslverr;
   logic                    pixel_clk;
   logic [PIX_W-1:0]        pixel_word_in;
   logic                    sequence_start_strobe;
   logic                    output_transfer_strobe;
   logic [NUM_CH*PIX_W-1:0] channel_outputs;
   logic                    white_level_sel;
   logic [31:0]             rd;
   logic                    err;
   logic [NUM_CH*PIX_W-1:0] snap;
   int                      failures = 0;
   int                      check_count = 0;
   int                      cycles = 0;

   dcl_loader dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pixel_clk(pixel_clk), .pixel_word_in(pixel_word_in),
      .sequence_start_strobe(sequence_start_strobe),
      .output_transfer_strobe(output_transfer_strobe),
      .channel_outputs(channel_outputs), .white_level_sel(white_level_sel)
   );

   dcl_tcon_model tcon
   (
      .pclk(pclk), .pixel_clk(pixel_clk), .pixel_word_in(pixel_word_in),
      .sequence_start_strobe(sequence_start_strobe),
      .output_transfer_strobe(output_transfer_strobe)
   );

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         failures++;
         report_and_stop();
      end
   end

   // ------------
   // Common tasks
   // ------------
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_chan(input logic [NUM_CH*PIX_W-1:0] got, input logic [NUM_CH*PIX_W-1:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Entered and left just after a rising edge
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
         failures++;
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Start cycle carries a decoy word that must never be latched
   task automatic load_seq(input logic [PIX_W-1:0] base, input int n);
      tcon.px(1'b1, 1'b0, 10'h3C3);
      for (int i = 0; i < n; i++)
         tcon.px(1'b0, 1'b0, base + PIX_W'(i));
   endtask

   task automatic xfer();
      tcon.px(1'b0, 1'b1, 10'h0AA);
      tcon.px(1'b0, 1'b0, 10'h155);
   endtask

   function automatic logic [NUM_CH*PIX_W-1:0] exp_ch(input logic [PIX_W-1:0] base,
                                                       input logic right);
      logic [NUM_CH*PIX_W-1:0] v;
      v = '0;
      for (int i = 0; i < NUM_CH; i++)
         v[(right ? NUM_CH - 1 - i : i) * PIX_W +: PIX_W] = base + PIX_W'(i);
      return v;
   endfunction

   // ------------
   // Scenarios
   // ------------
   task automatic t_regs();
      apb(1'b0, ADDR_CTRL, 32'h0);
      cmp_reg(rd, CTRL_RESET);
      apb(1'b1, 8'h02, 32'hFFFF_FFFF);
      cmp_reg({31'h0, err}, 32'h1);
      apb(1'b0, ADDR_CTRL, 32'h0);
      cmp_reg(rd, CTRL_RESET);
      apb(1'b0, 8'h40, 32'h0);
      cmp_reg(rd, 32'h0);
      cmp_reg({31'h0, err}, 32'h1);
      apb(1'b1, ADDR_CTRL, 32'hFFFF_FFF6);
      apb(1'b0, ADDR_CTRL, 32'h0);
      cmp_reg(rd, 32'h0000_0006);
      apb(1'b0, ADDR_LEVEL, 32'h0);
      cmp_reg(rd, 32'h0);
      $display("t_regs done");
   endtask

   task automatic t_even_left();
      apb(1'b1, ADDR_CTRL, 32'h1);
      load_seq(10'h201, 7);
      cmp_chan(channel_outputs, '0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      cmp_reg({31'h0, rd[ST_IGN_BIT]}, 32'h1);
      xfer();
      cmp_chan(channel_outputs, exp_ch(10'h201, 1'b0));
      $display("t_even_left done");
   endtask

   task automatic t_odd_right();
      apb(1'b1, ADDR_CTRL, 32'h2);
      load_seq(10'h0F0, 7);
      xfer();
      cmp_chan(channel_outputs, exp_ch(10'h0F0, 1'b1));
      $display("t_odd_right done");
   endtask

   task automatic t_polarity();
      apb(1'b1, ADDR_CTRL, 32'h5);
      snap = channel_outputs;
      load_seq(10'h3F8, 6);
      cmp_chan(channel_outputs, snap);
      xfer();
      cmp_chan(channel_outputs, exp_ch(10'h3F8, 1'b0));
      cmp_reg({31'h0, white_level_sel}, 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h1);
      xfer();
      cmp_reg({31'h0, white_level_sel}, 32'h1);
      xfer();
      cmp_reg({31'h0, white_level_sel}, 32'h0);
      $display("t_polarity done");
   endtask

   // Drain held back: three sequences overfill the buffer, the tail is dropped
   task automatic t_fifo();
      int n;
      apb(1'b1, ADDR_CTRL, 32'h9);
      load_seq(10'h100, 6);
      load_seq(10'h110, 6);
      load_seq(10'h120, 6);
      apb(1'b0, ADDR_LEVEL, 32'h0);
      cmp_reg(rd, 32'h10);
      apb(1'b0, ADDR_STATUS, 32'h0);
      cmp_reg(rd & 32'h106, 32'h104);
      apb(1'b1, ADDR_CTRL, 32'h1);
      n = 0;
      do
      begin
         apb(1'b0, ADDR_LEVEL, 32'h0);
         n++;
      end
      while (rd !== 32'h0 && n < 40);
      cmp_reg(rd, 32'h0);
      apb(1'b0, ADDR_STATUS, 32'h0);
      cmp_reg(rd & 32'h106, 32'h102);
      apb(1'b1, ADDR_STATUS, 32'h300);
      apb(1'b0, ADDR_STATUS, 32'h0);
      cmp_reg(rd & 32'h300, 32'h0);
      xfer();
      snap = exp_ch(10'h120, 1'b0);
      snap[59:40] = {10'h115, 10'h114};
      cmp_chan(channel_outputs, snap);
      apb(1'b0, ADDR_CHAN_LAST, 32'h0);
      cmp_reg(rd, 32'h115);
      apb(1'b0, ADDR_CHAN_BASE, 32'h0);
      cmp_reg(rd, 32'h120);
      $display("t_fifo done");
   endtask

   initial
   begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_even_left();
      t_odd_right();
      t_polarity();
      t_fifo();
      report_and_stop();
   end
endmodule
